// *** design/lte_consts.vh ***
// Purpose: constants for the lan transmit and event reporting block
// Assumes: 100 MHz clock_i, synchronous active-high reset
// Notes: command codes, mode and event values, field positions and timing counts
//
// Summary of operation
// - transmit command starts dma fetch then send
// - on tx done update status then interrupt
// - retransmit waits for pointer reload, then a full inter-attempt gap
// - retry collided frame until retry limit expires
// - drive end strobe on tx collision
// - trailing command byte low bits 100 chains
// - fatal transmit error reported via interrupt status
// - interrupt on command done or receive
// - alternate mode value suppresses receive interrupt
// - cause in status zero, bit 7 pending
// - status frozen while interrupt pending
// - one extra event queued in tight mode, shown after ack
// - one receive event covers many frames
// - no new interrupt until acknowledged
// - status reads advance pointer, release resets
// - end strobe on rx last byte, tx collision
// - sixteen collisions report count of zero
`ifndef LTE_CONSTS_VH
`define LTE_CONSTS_VH
`define LTE_CMD_XMT 3'h4
`define LTE_CMD_STATUS_POINTER_RELEASE_CMD 4'hf
`define LTE_CMD_ACK_BIT 7
`define LTE_MODE_TIGHT 8'h80
`define LTE_MODE_NO_RX_INT 8'hc0
`define LTE_ST_PEND_BIT 7
`define LTE_EV_XMT 4'h4
`define LTE_EV_REXMT 4'hc
`define LTE_EV_RCV 4'h8
`define LTE_EV_CMD 4'h2
`define LTE_MAX_RETRY 4'hf
`define LTE_STATUS_LEN 3'h6
`define LTE_GAP_NS 9600
`define LTE_CLK_NS 10
`define LTE_GAP_CYC (`LTE_GAP_NS / `LTE_CLK_NS)
`define LTE_RELOAD_CYC 4
`endif

// *** design/lte_buf2.v ***
// Purpose: two-entry valid/ready buffer in the data path
// Assumes: single clock, synchronous reset
// Notes: full and empty are exact; in_ready_o drops when both slots full
module lte_buf2 #(
   parameter WIDTH = 8
) (
   input wire clock_i,
   input wire sys_rst_i,
   input wire ce_i,
   input wire flush_i,
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [WIDTH-1:0] in_data_i,
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [WIDTH-1:0] out_data_o
);
   reg [WIDTH-1:0] mem_q [0:1];
   reg rd_q;
   reg wr_q;
   reg [1:0] cnt_q;
   wire push;
   wire pop;
   assign in_ready_o = (cnt_q != 2'd2);
   assign out_valid_o = (cnt_q != 2'd0);
   assign out_data_o = mem_q[rd_q];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;
   always @(posedge clock_i) begin
      if (sys_rst_i) begin
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         cnt_q <= 2'd0;
      end else if (ce_i) begin
         if (flush_i) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            cnt_q <= 2'd0;
         end else begin
            if (push) begin
               mem_q[wr_q] <= in_data_i;
               wr_q <= ~wr_q;
            end
            if (pop)
               rd_q <= ~rd_q;
            if (push & ~pop)
               cnt_q <= cnt_q + 2'd1;
            else if (pop & ~push)
               cnt_q <= cnt_q - 2'd1;
         end
      end
   end
endmodule

// *** design/lte_sync.v ***
// Purpose: two flip-flop synchroniser per bit for pin inputs
// Assumes: inputs asynchronous to clock_i
// Notes: first stage is read only by the second
module lte_sync #(
   parameter WIDTH = 4
) (
   input wire clock_i,
   input wire sys_rst_i,
   input wire ce_i,
   input wire [WIDTH-1:0] pin_i,
   output wire [WIDTH-1:0] sync_o
);
   genvar g;
   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : gen_bit
         reg s1_q;
         reg s2_q;
         always @(posedge clock_i) begin
            if (sys_rst_i) begin
               s1_q <= 1'b0;
               s2_q <= 1'b0;
            end else if (ce_i) begin
               s1_q <= pin_i[g];
               s2_q <= s1_q;
            end
         end
         assign sync_o[g] = s2_q;
      end
   endgenerate
endmodule

// *** design/lte_tx_event.v ***
// Purpose: transmit path and event reporting of a lan serial controller
// Assumes: external dma and glue reload the pointer on collision
// Notes: link events arrive on pins and are synchronised
`include "lte_consts.vh"
module lte_tx_event (
   input wire clock_i,
   input wire sys_rst_i,
   input wire ce_i,
   // host command port (same clock)
   input wire cmd_valid_i,
   input wire [7:0] cmd_i,
   input wire [7:0] buffer_length_mode_param_i,
   input wire rx_end_marker_enable_i,
   input wire tx_end_marker_enable_i,
   input wire chaining_en_i,
   input wire [3:0] max_retry_i,
   input wire stat_rd_i,
   output reg [7:0] stat_data_o,
   output reg int_o,
   // dma side (same clock)
   output reg dma_request_line_o,
   input wire dma_ack_i,
   input wire [7:0] dma_data_i,
   output reg end_of_process_strobe_n_o,
   input wire dma_reload_done_i,
   // link side
   output reg link_acquire_o,
   output reg link_valid_o,
   output reg [7:0] link_data_o,
   input wire link_ready_i,
   input wire link_collision_i,
   input wire link_fatal_i,
   input wire link_rx_frame_end_i,
   input wire link_rx_last_byte_i
);
   // ==========================================================
   // constants and states
   localparam ST_IDLE = 6'b000001;
   localparam ST_CNT = 6'b000010;
   localparam ST_DATA = 6'b000100;
   localparam ST_CMDB = 6'b001000;
   localparam ST_RELOAD = 6'b010000;
   localparam ST_BACKOFF = 6'b100000;
   localparam integer GAP_INT = `LTE_GAP_CYC;
   localparam integer RELOAD_INT = `LTE_RELOAD_CYC;
   localparam [15:0] GAP_CYC = GAP_INT[15:0];
   localparam [15:0] RELOAD_CYC = RELOAD_INT[15:0];

   // ==========================================================
   // pin synchronisers
   wire [3:0] pins_s;
   lte_sync #(.WIDTH(4)) u_sync (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .ce_i(ce_i),
      .pin_i({link_collision_i, link_fatal_i, link_rx_frame_end_i,
         link_rx_last_byte_i}),
      .sync_o(pins_s)
   );
   wire coll_s = pins_s[3];
   wire fatal_s = pins_s[2];
   wire rx_end_s = pins_s[1];
   wire rx_last_s = pins_s[0];
   reg coll_d1_q;
   reg fatal_d1_q;
   reg rx_end_d1_q;
   reg rx_last_d1_q;
   wire coll_ev = coll_s & ~coll_d1_q;
   wire fatal_ev = fatal_s & ~fatal_d1_q;
   wire rx_ev = rx_end_s & ~rx_end_d1_q;
   wire rx_last_ev = rx_last_s & ~rx_last_d1_q;

   // ==========================================================
   // transmit data buffer
   wire buf_in_valid;
   wire buf_in_ready;
   wire buf_out_valid;
   wire [7:0] buf_out_data;
   reg buf_flush;
   lte_buf2 #(.WIDTH(8)) u_buf (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .ce_i(ce_i),
      .flush_i(buf_flush),
      .in_valid_i(buf_in_valid),
      .in_ready_o(buf_in_ready),
      .in_data_i(dma_data_i),
      .out_valid_o(buf_out_valid),
      .out_ready_i(link_ready_i | ~link_valid_o),
      .out_data_o(buf_out_data)
   );

   // ==========================================================
   // transmit sequencer
   reg [5:0] state_q;
   reg [15:0] len_q;
   reg [15:0] left_q;
   reg cnt_hi_q;
   reg [4:0] tries_q;
   reg [15:0] timer_q;
   reg tx_done_p;
   reg tx_rexmt_p;
   reg tx_fatal_p;
   reg [4:0] coll_cnt_q;
   wire dma_take = dma_request_line_o & dma_ack_i;
   // a byte granted with no count left would be lost to the dma pointer
   assign buf_in_valid = dma_take & (state_q == ST_DATA)
      & (left_q != 16'h0000);
   // nothing moves to the link while the buffer is being flushed
   wire link_pop = buf_out_valid & (link_ready_i | ~link_valid_o)
      & ~buf_flush;
   wire buf_push = buf_in_valid & buf_in_ready;
   // request is registered, so look one byte ahead at buffer room
   wire buf_full_nx = ~link_pop
      & (~buf_in_ready | (buf_out_valid & buf_push));
   wire [15:0] left_nx = left_q - {15'h0000, buf_push};

   always @(posedge clock_i) begin
      if (sys_rst_i) begin
         state_q <= ST_IDLE;
         len_q <= 16'h0000;
         left_q <= 16'h0000;
         cnt_hi_q <= 1'b0;
         tries_q <= 5'h00;
         timer_q <= 16'h0000;
         dma_request_line_o <= 1'b0;
         end_of_process_strobe_n_o <= 1'b1;
         link_acquire_o <= 1'b0;
         link_valid_o <= 1'b0;
         link_data_o <= 8'h00;
         buf_flush <= 1'b0;
         tx_done_p <= 1'b0;
         tx_rexmt_p <= 1'b0;
         tx_fatal_p <= 1'b0;
         coll_cnt_q <= 5'h00;
      end else if (ce_i) begin
         tx_done_p <= 1'b0;
         tx_rexmt_p <= 1'b0;
         tx_fatal_p <= 1'b0;
         buf_flush <= 1'b0;
         end_of_process_strobe_n_o <= 1'b1;
         if (rx_last_ev & ~chaining_en_i & rx_end_marker_enable_i)
            end_of_process_strobe_n_o <= 1'b0;
         if (link_pop) begin
            link_valid_o <= 1'b1;
            link_data_o <= buf_out_data;
         end else if (link_ready_i)
            link_valid_o <= 1'b0;
         case (state_q)
         ST_IDLE: begin
            if (cmd_valid_i && cmd_i[2:0] == `LTE_CMD_XMT) begin
               state_q <= ST_CNT;
               dma_request_line_o <= 1'b1;
               cnt_hi_q <= 1'b0;
               tries_q <= 5'h00;
            end
         end
         ST_CNT: begin
            if (dma_take) begin
               cnt_hi_q <= ~cnt_hi_q;
               if (!cnt_hi_q)
                  len_q[7:0] <= dma_data_i;
               else begin
                  len_q[15:8] <= dma_data_i;
                  left_q <= {dma_data_i, len_q[7:0]};
                  state_q <= ST_DATA;
               end
            end
         end
         ST_DATA: begin
            // back-pressure: stop fetching while the buffer is full
            dma_request_line_o <= ~buf_full_nx & (left_nx != 16'h0000);
            if (buf_out_valid)
               link_acquire_o <= 1'b1;
            if (buf_in_valid)
               left_q <= left_q - 16'h0001;
            if (fatal_ev) begin
               tx_fatal_p <= 1'b1;
               state_q <= ST_IDLE;
               dma_request_line_o <= 1'b0;
               link_acquire_o <= 1'b0;
               link_valid_o <= 1'b0;
               buf_flush <= 1'b1;
            end else if (coll_ev) begin
               dma_request_line_o <= 1'b0;
               link_acquire_o <= 1'b0;
               link_valid_o <= 1'b0;
               buf_flush <= 1'b1;
               if (~chaining_en_i & tx_end_marker_enable_i)
                  end_of_process_strobe_n_o <= 1'b0;
               if (tries_q >= {1'b0, max_retry_i}) begin
                  tx_rexmt_p <= 1'b1;
                  coll_cnt_q <= 5'h00;
                  state_q <= ST_IDLE;
               end else begin
                  tries_q <= tries_q + 5'h01;
                  timer_q <= RELOAD_CYC;
                  state_q <= ST_RELOAD;
               end
            end else if (left_q == 16'h0000 && !buf_out_valid
                  && !link_valid_o) begin
               state_q <= ST_CMDB;
               dma_request_line_o <= 1'b1;
               link_acquire_o <= 1'b0;
            end
         end
         ST_CMDB: begin
            if (dma_take) begin
               coll_cnt_q <= tries_q;
               tx_done_p <= 1'b1;
               if (dma_data_i[2:0] == `LTE_CMD_XMT) begin
                  state_q <= ST_CNT;
                  cnt_hi_q <= 1'b0;
                  tries_q <= 5'h00;
               end else begin
                  state_q <= ST_IDLE;
                  dma_request_line_o <= 1'b0;
               end
            end
         end
         ST_RELOAD: begin
            // wait for the reload, but at least a short settle time
            if (timer_q != 16'h0000)
               timer_q <= timer_q - 16'h0001;
            else if (dma_reload_done_i) begin
               timer_q <= GAP_CYC;
               state_q <= ST_BACKOFF;
            end
         end
         ST_BACKOFF: begin
            if (timer_q != 16'h0000)
               timer_q <= timer_q - 16'h0001;
            else begin
               state_q <= ST_CNT;
               cnt_hi_q <= 1'b0;
               dma_request_line_o <= 1'b1;
            end
         end
         default: state_q <= ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // event reporting: status, queue and interrupt
   reg pend_q;
   reg [3:0] cause_q;
   reg q_valid_q;
   reg [3:0] q_cause_q;
   reg [6:0] frame_cnt_q;
   reg [4:0] st_coll_q;
   reg [6:0] st_frame_q;
   reg [2:0] ptr_q;
   reg rx_reported_q;
   reg [3:0] new_cause;
   reg new_ev;
   wire ack = cmd_valid_i & cmd_i[`LTE_CMD_ACK_BIT];
   wire tight = (buffer_length_mode_param_i == `LTE_MODE_TIGHT);
   wire rx_int_ok = (buffer_length_mode_param_i != `LTE_MODE_NO_RX_INT);
   wire cmd_done = cmd_valid_i & ~cmd_i[`LTE_CMD_ACK_BIT]
      & (cmd_i[2:0] != `LTE_CMD_XMT) & (cmd_i[3:0] != `LTE_CMD_STATUS_POINTER_RELEASE_CMD)
      & (cmd_i[3:0] != 4'h0);

   always @* begin
      new_ev = 1'b1;
      new_cause = `LTE_EV_XMT;
      if (tx_done_p)
         new_cause = `LTE_EV_XMT;
      else if (tx_rexmt_p | tx_fatal_p)
         new_cause = `LTE_EV_REXMT;
      else if (cmd_done)
         new_cause = `LTE_EV_CMD;
      else if (rx_ev & rx_int_ok & ~rx_reported_q)
         new_cause = `LTE_EV_RCV;
      else
         new_ev = 1'b0;
   end

   always @(posedge clock_i) begin
      if (sys_rst_i) begin
         coll_d1_q <= 1'b0;
         fatal_d1_q <= 1'b0;
         rx_end_d1_q <= 1'b0;
         rx_last_d1_q <= 1'b0;
         pend_q <= 1'b0;
         cause_q <= 4'h0;
         q_valid_q <= 1'b0;
         q_cause_q <= 4'h0;
         frame_cnt_q <= 7'h00;
         st_coll_q <= 5'h00;
         st_frame_q <= 7'h00;
         ptr_q <= 3'h0;
         rx_reported_q <= 1'b0;
         int_o <= 1'b0;
         stat_data_o <= 8'h00;
      end else if (ce_i) begin
         coll_d1_q <= coll_s;
         fatal_d1_q <= fatal_s;
         rx_end_d1_q <= rx_end_s;
         rx_last_d1_q <= rx_last_s;
         if (rx_ev)
            frame_cnt_q <= frame_cnt_q + 7'h01;
         if (cmd_valid_i && cmd_i[3:0] == `LTE_CMD_STATUS_POINTER_RELEASE_CMD)
            ptr_q <= 3'h0;
         else if (stat_rd_i)
            ptr_q <= (ptr_q == `LTE_STATUS_LEN - 3'h1) ? 3'h0
               : ptr_q + 3'h1;
         if (ack && pend_q) begin
            if (q_valid_q) begin
               cause_q <= q_cause_q;
               st_coll_q <= coll_cnt_q;
               st_frame_q <= frame_cnt_q;
               q_valid_q <= new_ev & tight;
               q_cause_q <= new_cause;
               pend_q <= 1'b1;
               int_o <= 1'b0; // re-raised next cycle
            end else if (new_ev) begin
               cause_q <= new_cause;
               st_coll_q <= coll_cnt_q;
               st_frame_q <= frame_cnt_q;
               pend_q <= 1'b1;
               int_o <= 1'b0;
            end else begin
               pend_q <= 1'b0;
               int_o <= 1'b0;
            end
            // a receive event now shown or queued keeps merging frames
            rx_reported_q <= (q_valid_q && q_cause_q == `LTE_EV_RCV)
               || (new_ev && new_cause == `LTE_EV_RCV);
         end else begin
            if (pend_q && !int_o && !ack)
               int_o <= 1'b1;
            if (new_ev) begin
               if (!pend_q) begin
                  cause_q <= new_cause;
                  st_coll_q <= coll_cnt_q;
                  st_frame_q <= frame_cnt_q;
                  pend_q <= 1'b1;
                  int_o <= 1'b1;
               end else if (tight && !q_valid_q) begin
                  q_valid_q <= 1'b1;
                  q_cause_q <= new_cause;
               end
               if (new_cause == `LTE_EV_RCV)
                  rx_reported_q <= 1'b1;
            end
         end
         // status frozen while pending, reads only select bytes
         case (ptr_q)
         3'h0: stat_data_o <= {pend_q, 3'h0, cause_q};
         3'h1: stat_data_o <= {3'h0, st_coll_q};
         3'h2: stat_data_o <= {1'b1, st_frame_q};
         default: stat_data_o <= 8'h00;
         endcase
      end
   end
endmodule

// *** tb/lte_tx_event_assertions.sv ***
// Purpose: port checker for lte_tx_event
// Assumes: one clock domain, synchronous active-high reset
// Notes: bound from the bench top file
module lte_tx_event_assertions (
   input wire clock_i,
   input wire sys_rst_i,
   input wire cmd_valid_i,
   input wire [7:0] cmd_i,
   input wire stat_rd_i,
   input wire [7:0] stat_data_o,
   input wire int_o,
   input wire dma_request_line_o,
   input wire end_of_process_strobe_n_o,
   input wire link_acquire_o,
   input wire link_valid_o,
   input wire [7:0] link_data_o,
   input wire link_ready_i,
   input wire link_collision_i
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========
   // sequences
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (sys_rst_i);
   sequence ack_s;
      int_o && cmd_valid_i && cmd_i[7];
   endsequence
   sequence quiet_s;
      (int_o && !stat_rd_i && !cmd_valid_i) [*3];
   endsequence
   sequence idle_xmt_s;
      cmd_valid_i && cmd_i == 8'h04 && !int_o && !dma_request_line_o;
   endsequence
   // ==========
   // properties
   AST_INT_HOLD: assert property (
      int_o && !(cmd_valid_i && cmd_i[7]) |=> int_o)
      else $error("interrupt dropped without acknowledge");
   AST_ACK_DROP: assert property (
      ack_s |=> !int_o)
      else $error("interrupt held after acknowledge");
   AST_STAT_FROZEN: assert property (
      quiet_s |=> $stable(stat_data_o))
      else $error("status changed while event pending");
   AST_XMT_REQ: assert property (
      idle_xmt_s ##0 !link_acquire_o |-> ##[1:2] dma_request_line_o)
      else $error("no data request after transmit command");
   AST_EOP_PULSE: assert property (
      !end_of_process_strobe_n_o |=> end_of_process_strobe_n_o)
      else $error("end strobe longer than one cycle");
   AST_EOP_STOP: assert property (
      !end_of_process_strobe_n_o |=> !dma_request_line_o [*3])
      else $error("data request before pointer reload");
   AST_COLL_EOP: assert property (
      $rose(link_collision_i) && link_acquire_o
         |-> ##[2:8] !end_of_process_strobe_n_o)
      else $error("no end strobe after collision");
   AST_LINK_HOLD: assert property (
      link_valid_o && !link_ready_i
         |=> (link_valid_o && $stable(link_data_o)) || !link_acquire_o)
      else $error("link byte lost during stall");
   AST_LINK_ACQ: assert property (
      link_valid_o |-> link_acquire_o)
      else $error("link data without link acquired");
   AST_CMD_INT: assert property (
      cmd_valid_i && cmd_i == 8'h01 && !int_o |-> ##[1:3] int_o)
      else $error("no interrupt after command completion");
endmodule

// *** tb/lte_dma_model.sv ***
// Purpose: dma controller and retransmit glue facing lte_tx_event
// Assumes: frame image written into mem_q by the bench
// Notes: slow_i answers every other cycle
module lte_dma_model (
   input wire clock_i,
   input wire sys_rst_i,
   input wire restart_i,
   input wire slow_i,
   input wire dma_req_i,
   input wire eop_n_i,
   output wire dma_ack_o,
   output wire [7:0] dma_data_o,
   output wire reload_done_o
);
   timeunit 1ns;
   timeprecision 1ps;
   reg [7:0] mem_q [0:31];
   reg [4:0] ptr_q;
   reg [2:0] wait_q;
   reg ack_q;
   reg done_q;
   reg [7:0] last_q;
   assign dma_ack_o = ack_q;
   // idle bus never shows the last byte again
   assign dma_data_o = ack_q ? mem_q[ptr_q] : ~last_q;
   assign reload_done_o = done_q;
   always @(posedge clock_i) begin
      if (sys_rst_i || restart_i) begin
         ptr_q <= 5'h00;
         ack_q <= 1'b0;
         wait_q <= 3'h0;
         done_q <= 1'b1;
      end else if (!eop_n_i) begin
         // strobe forces the pointer back to the frame start
         ptr_q <= 5'h00;
         ack_q <= 1'b0;
         done_q <= 1'b0;
         wait_q <= 3'h4;
      end else if (wait_q != 3'h0) begin
         wait_q <= wait_q - 3'h1;
         done_q <= (wait_q == 3'h1);
      end else begin
         if (ack_q && dma_req_i) begin
            ptr_q <= ptr_q + 5'h01;
            last_q <= mem_q[ptr_q];
         end
         ack_q <= dma_req_i && !(slow_i && ack_q);
      end
   end
endmodule

// *** tb/lte_tx_event_bench.sv ***
// Purpose: self-checking bench for lte_tx_event
// Assumes: inputs change on the falling edge of clock_i
// Notes: link sink stalls every other cycle when stall_q is set
`include "lte_consts.vh"
module lte_tx_event_bench;
   timeunit 1ns;
   timeprecision 1ps;
   reg clock_i = 1'b0;
   reg sys_rst_i = 1'b1;
   reg cmd_valid_i = 1'b0;
   reg [7:0] cmd_i = 8'h00;
   reg [7:0] mode_q = 8'h80;
   reg stat_rd_i = 1'b0;
   reg ready_q = 1'b1;
   reg stall_q = 1'b0;
   reg slow_q = 1'b0;
   reg restart_q = 1'b0;
   reg ce_q = 1'b1;
   reg [3:0] pins_q = 4'h0;
   wire [7:0] stat_data_o, link_data_o, dma_data;
   wire int_o, dma_req, dma_ack, eop_n, reload, acq, link_valid;
   int num_errors = 0;
   int n_tests = 0;
   int lk_cnt = 0;
   int k;
   // ==========
   // design, partner, clock
   lte_tx_event u_lte_tx_event (
      .clock_i(clock_i), .sys_rst_i(sys_rst_i), .ce_i(ce_q),
      .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
      .buffer_length_mode_param_i(mode_q), .rx_end_marker_enable_i(1'b1),
      .tx_end_marker_enable_i(1'b1), .chaining_en_i(1'b0),
      .max_retry_i(`LTE_MAX_RETRY), .stat_rd_i(stat_rd_i),
      .stat_data_o(stat_data_o), .int_o(int_o),
      .dma_request_line_o(dma_req), .dma_ack_i(dma_ack),
      .dma_data_i(dma_data), .end_of_process_strobe_n_o(eop_n),
      .dma_reload_done_i(reload), .link_acquire_o(acq),
      .link_valid_o(link_valid), .link_data_o(link_data_o),
      .link_ready_i(ready_q), .link_collision_i(pins_q[2]),
      .link_fatal_i(pins_q[3]), .link_rx_frame_end_i(pins_q[1]),
      .link_rx_last_byte_i(pins_q[0]));
   lte_dma_model u_lte_dma_model (
      .clock_i(clock_i), .sys_rst_i(sys_rst_i), .restart_i(restart_q),
      .slow_i(slow_q), .dma_req_i(dma_req), .eop_n_i(eop_n),
      .dma_ack_o(dma_ack), .dma_data_o(dma_data), .reload_done_o(reload));
   initial forever #5 clock_i = ~clock_i;
   always @(negedge clock_i) ready_q <= stall_q ? ~ready_q : 1'b1;
   always @(posedge clock_i) begin
      if (eop_n === 1'b0) lk_cnt = 0;
      else if (link_valid === 1'b1 && ready_q) begin
         check(link_data_o, 8'h30 + lk_cnt[7:0], "link byte");
         lk_cnt++;
      end
   end
   // ==========
   // tasks
   task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                        input string what);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   function automatic logic pick(input int sel);
      case (sel)
         0: pick = int_o;
         1: pick = eop_n;
         2: pick = dma_req;
         default: pick = acq;
      endcase
   endfunction
   task automatic wait_for(input int sel, input logic lvl, input int bound);
      int i;
      for (i = 0; i < bound && pick(sel) !== lvl; i++) @(negedge clock_i);
      check(pick(sel), lvl, "awaited output");
      if (pick(sel) !== lvl) end_sim;
   endtask
   task automatic send(input logic [7:0] v);
      @(negedge clock_i);
      cmd_valid_i = 1'b1;
      cmd_i = v;
      @(negedge clock_i);
      cmd_valid_i = 1'b0;
   endtask
   task automatic pin_pulse(input int sel);
      @(negedge clock_i) pins_q[sel] = 1'b1;
      repeat (2) @(negedge clock_i);
      pins_q[sel] = 1'b0;
   endtask
   task automatic stat(input int idx, input logic [7:0] exp, input string w);
      int j;
      send({4'h0, `LTE_CMD_STATUS_POINTER_RELEASE_CMD});
      for (j = 0; j < idx; j++) begin
         @(negedge clock_i) stat_rd_i = 1'b1;
         @(negedge clock_i) stat_rd_i = 1'b0;
      end
      repeat (2) @(negedge clock_i);
      check(stat_data_o, exp, w);
   endtask
   task automatic xmit(input int n);
      int i;
      @(negedge clock_i) restart_q = 1'b1;
      u_lte_dma_model.mem_q[0] = n[7:0];
      u_lte_dma_model.mem_q[1] = 8'h00;
      for (i = 0; i < n; i++) u_lte_dma_model.mem_q[i + 2] = 8'h30 + i[7:0];
      u_lte_dma_model.mem_q[n + 2] = 8'h00;
      @(negedge clock_i) restart_q = 1'b0;
      lk_cnt = 0;
      send({5'h00, `LTE_CMD_XMT});
   endtask
   task automatic collide(input logic last);
      wait_for(3, 1'b1, 200);
      pin_pulse(2);
      if (!last) wait_for(1, 1'b0, 20);
      repeat (3) @(negedge clock_i);
   endtask
   // ==========
   // tests
   initial begin
      repeat (20) @(negedge clock_i);
      sys_rst_i = 1'b0;
      check(int_o, 1'b0, "int after reset");
      stall_q = 1'b1;
      xmit(12);
      wait_for(0, 1'b1, 3000);
      check(lk_cnt[7:0], 8'h0c, "bytes sent");
      stat(0, {1'b1, 3'h0, `LTE_EV_XMT}, "tx status");
      send(8'h80);
      check(int_o, 1'b0, "int after ack");
      $display("test transmit finished");
      stall_q = 1'b0;
      send(8'h01);
      wait_for(0, 1'b1, 10);
      pin_pulse(1);
      pin_pulse(1);
      send(8'h01);
      stat(0, {1'b1, 3'h0, `LTE_EV_CMD}, "held status");
      send(8'h80);
      wait_for(0, 1'b1, 10);
      stat(0, {1'b1, 3'h0, `LTE_EV_RCV}, "queued status");
      stat(2, 8'h82, "frame count");
      send(8'h80);
      repeat (10) @(negedge clock_i);
      check(int_o, 1'b0, "merged receive");
      pin_pulse(0);
      wait_for(1, 1'b0, 12);
      $display("test event queue finished");
      slow_q = 1'b1;
      xmit(8);
      collide(1'b0);
      check(dma_req, 1'b0, "request after collision");
      wait_for(0, 1'b1, 5000);
      check(lk_cnt[7:0], 8'h08, "bytes resent");
      stat(1, 8'h01, "collision count");
      send(8'h80);
      xmit(8);
      for (k = 0; k < 16; k++) begin
         wait_for(2, 1'b1, 3000);
         collide(k == 15);
      end
      wait_for(0, 1'b1, 200);
      stat(0, {1'b1, 3'h0, `LTE_EV_REXMT}, "retry limit");
      stat(1, 8'h00, "count wraps");
      send(8'h80);
      $display("test collision finished");
      xmit(8);
      wait_for(3, 1'b1, 200);
      pin_pulse(3);
      wait_for(0, 1'b1, 50);
      stat(0, {1'b1, 3'h0, `LTE_EV_REXMT}, "fatal status");
      send(8'h80);
      mode_q = `LTE_MODE_NO_RX_INT;
      pin_pulse(1);
      repeat (20) @(negedge clock_i);
      check(int_o, 1'b0, "no receive int");
      mode_q = `LTE_MODE_TIGHT;
      ce_q = 1'b0;
      pin_pulse(1);
      repeat (4) @(negedge clock_i);
      ce_q = 1'b1;
      repeat (6) @(negedge clock_i);
      check(int_o, 1'b0, "frozen receive");
      pin_pulse(1);
      wait_for(0, 1'b1, 10);
      $display("test fatal and mode finished");
      end_sim;
   end
endmodule
bind lte_tx_event lte_tx_event_assertions u_lte_tx_event_assertions (
   .clock_i(clock_i), .sys_rst_i(sys_rst_i), .cmd_valid_i(cmd_valid_i),
   .cmd_i(cmd_i), .stat_rd_i(stat_rd_i), .stat_data_o(stat_data_o),
   .int_o(int_o), .dma_request_line_o(dma_request_line_o),
   .end_of_process_strobe_n_o(end_of_process_strobe_n_o),
   .link_acquire_o(link_acquire_o), .link_valid_o(link_valid_o),
   .link_data_o(link_data_o), .link_ready_i(link_ready_i),
   .link_collision_i(link_collision_i));
